// [rtl/ncig_map.svh]
// Register map, field positions and limits of the configuration guard
// Assumes 32-bit APB data and byte addresses on paddr
`ifndef NCIG_MAP_SVH
`define NCIG_MAP_SVH
// ==========================================================
// Register byte offsets
`define NCIG_A_CTRL    8'h00
`define NCIG_A_PAGE    8'h04
`define NCIG_A_VOUT    8'h08
`define NCIG_A_RANGE   8'h0c
`define NCIG_A_GCFG    8'h10
`define NCIG_A_SWORD   8'h14
`define NCIG_A_SMFR    8'h18
`define NCIG_A_IST     8'h1c
`define NCIG_A_IMASK   8'h20
`define NCIG_A_FMASK   8'h24
`define NCIG_A_FLATCH  8'h28
`define NCIG_A_PROP    8'h2c
`define NCIG_A_NADDR   8'h30
`define NCIG_A_NDATA   8'h34
`define NCIG_A_DEVADR  8'h38
`define NCIG_A_DAC     8'h3c
`define NCIG_A_TEMP    8'h40
// ==========================================================
// Field positions
`define NCIG_CTRL_RESTORE 0
`define NCIG_CTRL_FCLR    1
`define NCIG_GCFG_IGN_RC  6
`define NCIG_SB_MFR       0
`define NCIG_SB_TEMP      2
`define NCIG_SW_MFR       12
`define NCIG_IRQ_CRC      0
`define NCIG_IRQ_OT       1
`define NCIG_IRQ_WBLK     2
`define NCIG_IRQ_F0       3
`define NCIG_IRQ_F1       4
// ==========================================================
// Addresses, temperatures in degrees C, conversion constants
`define NCIG_ADDR_RECOV  7'h7c
`define NCIG_ADDR_GLOB0  7'h5a
`define NCIG_ADDR_GLOB1  7'h5b
`define NCIG_ADDR_RST    7'h40
`define NCIG_WBLK_ON_C   12'h082
`define NCIG_WBLK_OFF_C  12'h07d
`define NCIG_OT_C        12'h0a0
`define NCIG_OT_HYST_C   12'h00a
`define NCIG_CRC_POLY    16'h1021
`define NCIG_CRC_INIT    16'h0000
`define NCIG_DAC_DIV     20'h0000b
`define NCIG_DAC_MAX     20'h00fff
`endif

// [rtl/ncig_pkg.sv]
// Types shared by the configuration guard
// Assumes constants come from ncig_map.svh
package ncig_pkg;
   // ==========================================================
   // Configuration load sequencer
   typedef enum logic [1:0] {NCIG_IDLE, NCIG_LOAD, NCIG_CHECK} ncig_load_t;
endpackage : ncig_pkg

// [rtl/ncig_top.sv]
// Configuration memory guard: CRC load, temperature locks, setpoints
// Assumes APB master on pclk, die temperature from telemetry logic
//
// Contract
// - CRC checked over config memory on every load, reset and restore.
// - CRC failure sets manufacturer summary bit in status byte and word.
// - CRC failure sets memory CRC flag, pulls alert and run low.
// - After CRC failure answer only 0x7C, 0x5A and 0x5B.
// - Memory writes blocked while die temperature above 130 C.
// - Blocked writes re-enabled only below 125 C.
// - Controller off above 160 C, back on after 10 C drop.
// - Fault log writes reach only fault log locations.
// - Page value selects channel 0 or 1 for channel commands.
// - Setpoint is a 12-bit code over 0 to 1.024 V.
// - Scale factor 5.5, or 2.75 when channel range is 1.
// - Target from resistor config inputs or output voltage command.
// - New output voltage command takes effect within 10 ms.
// - Each fault maskable, and hiccup or latched off.
// - Two fault outputs with independent masks plus alert output.
// - Write protect input high restricts accepted writes.
// - Global config bit 6 ignores resistor config inputs.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`include "ncig_map.svh"
`timescale 1ns/1ps
module ncig_top #(
   parameter int DEPTH = 16,
   parameter int CFG_WORDS = 4,
   parameter int NF = 4
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   input  wire logic [11:0]       die_temp,
   input  wire logic              die_temp_valid,
   input  wire logic              write_protect,
   input  wire logic [1:0]        resistor_config_present,
   input  wire logic [15:0]       resistor_config_mv0,
   input  wire logic [15:0]       resistor_config_mv1,
   input  wire logic [2*NF-1:0]   fault_in,
   input  wire logic              flog_we,
   input  wire logic [$clog2(DEPTH)-1:0] flog_addr,
   input  wire logic [15:0]       flog_data,
   output      logic              flog_ack,
   input  wire logic [6:0]        smb_addr,
   input  wire logic              smb_addr_valid,
   output      logic              smb_addr_ack,
   output      logic [1:0]        run_oe,
   output      logic              alert_oe,
   output      logic              fault_output_zero_oe,
   output      logic              fault_output_one_oe,
   output      logic              irq,
   output      logic [11:0]       dac_code0,
   output      logic [11:0]       dac_code1
);
   localparam int IW = $clog2(DEPTH);

   // ==========================================================
   // State
   typedef struct packed {
      logic [DEPTH-1:0][15:0]  mem;
      ncig_pkg::ncig_load_t    ld;
      logic [IW-1:0]           idx;
      logic [15:0]             crc;
      logic                    crc_fail;
      logic [11:0]             temp;
      logic                    wr_blk;
      logic                    ot_off;
      logic                    page;
      logic [1:0][15:0]        vout;
      logic [1:0]              range;
      logic [7:0]              gcfg;
      logic [6:0]              dev_addr;
      logic [4:0]              ist;
      logic [4:0]              imask;
      logic [1:0][NF-1:0]      fmask;
      logic [1:0][NF-1:0]      fmode;
      logic [1:0][NF-1:0]      flat;
      logic [1:0]              chf;
      logic [1:0]              prop0;
      logic [1:0]              prop1;
      logic [IW-1:0]           nptr;
      logic                    wok;
      logic                    pready;
      logic                    pslverr;
      logic [31:0]             prdata;
      logic [1:0]              run_oe;
      logic                    alert;
      logic                    fo0;
      logic                    fo1;
      logic                    irq;
      logic                    ack;
      logic                    flog_ack;
      logic [1:0][11:0]        dac;
   } ncig_state_t;

   ncig_state_t s_q;
   ncig_state_t s_d;

   // ==========================================================
   // Functions
   function automatic logic [15:0] ncig_crc16(input logic [15:0] c,
                                              input logic [15:0] w);
      logic [15:0] r;
      r = c;
      for (int i = 15; i >= 0; i--)
      begin
         if (r[15] ^ w[i])
            r = {r[14:0], 1'b0} ^ `NCIG_CRC_POLY;
         else
            r = {r[14:0], 1'b0};
      end
      return r;
   endfunction : ncig_crc16

   // One code is 0.25 mV of reference: mv*4/5.5 or mv*4/2.75
   function automatic logic [11:0] ncig_code(input logic [15:0] mv,
                                             input logic rng);
      logic [19:0] p;
      logic [19:0] q;
      p = rng ? {mv, 4'h0} : {1'b0, mv, 3'h0};
      q = p / `NCIG_DAC_DIV;
      return (q > `NCIG_DAC_MAX) ? 12'hfff : q[11:0];
   endfunction : ncig_code

   // Register decode: 0 unmapped, 1 mapped, 2 writable under protect
   function automatic logic [1:0] ncig_dec(input logic [7:0] a);
      logic [1:0] r;
      r = 2'h1;
      unique case (a)
         `NCIG_A_PAGE, `NCIG_A_IST, `NCIG_A_IMASK: r = 2'h2;
         `NCIG_A_CTRL, `NCIG_A_VOUT, `NCIG_A_RANGE, `NCIG_A_GCFG,
         `NCIG_A_SWORD, `NCIG_A_SMFR, `NCIG_A_FMASK, `NCIG_A_FLATCH,
         `NCIG_A_PROP, `NCIG_A_NADDR, `NCIG_A_NDATA, `NCIG_A_DEVADR,
         `NCIG_A_DAC, `NCIG_A_TEMP: r = 2'h1;
         default: r = 2'h0;
      endcase
      return r;
   endfunction : ncig_dec

   // ==========================================================
   // Next state
   always_comb
   begin
      logic          acc;
      logic [1:0]    dk;
      logic          ro;
      logic [4:0]    ev;
      logic [NF-1:0] fin;
      logic [NF-1:0] act;
      logic [15:0]   mv;
      logic          rcl;
      logic          fclr;
      logic [31:0]   rd;
      acc  = psel & penable & s_q.pready;
      dk   = ncig_dec(paddr);
      ro   = (paddr == `NCIG_A_SWORD) || (paddr == `NCIG_A_SMFR)
             || (paddr == `NCIG_A_DAC) || (paddr == `NCIG_A_TEMP);
      ev   = 5'h00;
      fin  = '0;
      act  = '0;
      mv   = 16'h0000;
      rcl  = 1'b0;
      fclr = 1'b0;
      rd   = 32'h00000000;
      s_d  = s_q;

      // Latest die temperature held here
      if (die_temp_valid)
         s_d.temp = die_temp;
      if ($signed(s_q.temp) > $signed(`NCIG_WBLK_ON_C))
         s_d.wr_blk = 1'b1;
      else if ($signed(s_q.temp) < $signed(`NCIG_WBLK_OFF_C))
         s_d.wr_blk = 1'b0;
      if ($signed(s_q.temp) > $signed(`NCIG_OT_C))
         s_d.ot_off = 1'b1;
      else if ($signed(s_q.temp)
               < $signed(`NCIG_OT_C - `NCIG_OT_HYST_C))
         s_d.ot_off = 1'b0;
      ev[`NCIG_IRQ_OT] = s_d.ot_off & ~s_q.ot_off;

      // ==========================================================
      // APB slave, one wait state
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      if (psel & penable & ~s_q.pready)
      begin
         s_d.pready = 1'b1;
         s_d.wok = (dk != 2'h0) && !(pwrite && ro)
                   && !(pwrite && write_protect && dk != 2'h2);
         if (pwrite && paddr == `NCIG_A_NDATA
             && (s_q.wr_blk || s_q.ld != ncig_pkg::NCIG_IDLE))
            s_d.wok = 1'b0;
         s_d.pslverr = ~s_d.wok;
         unique case (paddr)
            `NCIG_A_PAGE:   rd[0] = s_q.page;
            `NCIG_A_VOUT:   rd[15:0] = s_q.vout[s_q.page];
            `NCIG_A_RANGE:  rd[0] = s_q.range[s_q.page];
            `NCIG_A_GCFG:   rd[7:0] = s_q.gcfg;
            `NCIG_A_SWORD:
            begin
               rd[`NCIG_SB_MFR] = s_q.crc_fail;
               rd[`NCIG_SW_MFR] = s_q.crc_fail;
               rd[`NCIG_SB_TEMP] = s_q.ot_off;
            end
            `NCIG_A_SMFR:   rd[1:0] = {s_q.wr_blk, s_q.crc_fail};
            `NCIG_A_IST:    rd[4:0] = s_q.ist;
            `NCIG_A_IMASK:  rd[4:0] = s_q.imask;
            `NCIG_A_FMASK:  rd[NF-1:0] = s_q.fmask[s_q.page];
            `NCIG_A_FLATCH: rd[NF-1:0] = s_q.fmode[s_q.page];
            `NCIG_A_PROP:   rd[3:0] = {s_q.prop1, s_q.prop0};
            `NCIG_A_NADDR:  rd[IW-1:0] = s_q.nptr;
            `NCIG_A_NDATA:  rd[15:0] = s_q.mem[s_q.nptr];
            `NCIG_A_DEVADR: rd[6:0] = s_q.dev_addr;
            `NCIG_A_DAC:    rd[11:0] = s_q.dac[s_q.page];
            `NCIG_A_TEMP:   rd[11:0] = s_q.temp;
            default:        rd = 32'h00000000;
         endcase
         s_d.prdata = pwrite ? 32'h00000000 : rd;
      end
      if (acc && pwrite && !s_q.wok && paddr == `NCIG_A_NDATA)
         ev[`NCIG_IRQ_WBLK] = 1'b1;
      if (acc && pwrite && s_q.wok)
      begin
         unique case (paddr)
            `NCIG_A_CTRL:
            begin
               rcl = pwdata[`NCIG_CTRL_RESTORE];
               fclr = pwdata[`NCIG_CTRL_FCLR];
            end
            `NCIG_A_PAGE:   s_d.page = pwdata[0];
            `NCIG_A_VOUT:   s_d.vout[s_q.page] = pwdata[15:0];
            `NCIG_A_RANGE:  s_d.range[s_q.page] = pwdata[0];
            `NCIG_A_GCFG:   s_d.gcfg = pwdata[7:0];
            `NCIG_A_IST:    s_d.ist = s_q.ist & ~pwdata[4:0];
            `NCIG_A_IMASK:  s_d.imask = pwdata[4:0];
            `NCIG_A_FMASK:  s_d.fmask[s_q.page] = pwdata[NF-1:0];
            `NCIG_A_FLATCH: s_d.fmode[s_q.page] = pwdata[NF-1:0];
            `NCIG_A_PROP:
            begin
               s_d.prop0 = pwdata[1:0];
               s_d.prop1 = pwdata[3:2];
            end
            `NCIG_A_NADDR:  s_d.nptr = pwdata[IW-1:0];
            `NCIG_A_NDATA:  s_d.mem[s_q.nptr] = pwdata[15:0];
            `NCIG_A_DEVADR: s_d.dev_addr = pwdata[6:0];
            default:        s_d.page = s_q.page;
         endcase
      end

      // ==========================================================
      // Fault log writes, own region only, not while hot
      s_d.flog_ack = 1'b0;
      if (flog_we && !s_q.wr_blk && 32'(flog_addr) > CFG_WORDS
          && !(acc && pwrite && s_q.wok && paddr == `NCIG_A_NDATA))
      begin
         s_d.mem[flog_addr] = flog_data;
         s_d.flog_ack = 1'b1;
      end

      // ==========================================================
      // Configuration load and CRC check
      unique case (s_q.ld)
         ncig_pkg::NCIG_IDLE:
            if (rcl)
            begin
               s_d.ld = ncig_pkg::NCIG_LOAD;
               s_d.idx = '0;
               s_d.crc = `NCIG_CRC_INIT;
            end
         ncig_pkg::NCIG_LOAD:
         begin
            s_d.crc = ncig_crc16(s_q.crc, s_q.mem[s_q.idx]);
            s_d.idx = s_q.idx + IW'(1);
            if (32'(s_q.idx) == CFG_WORDS - 1)
               s_d.ld = ncig_pkg::NCIG_CHECK;
         end
         ncig_pkg::NCIG_CHECK:
         begin
            s_d.ld = ncig_pkg::NCIG_IDLE;
            s_d.crc_fail = (s_q.crc != s_q.mem[CFG_WORDS]);
            ev[`NCIG_IRQ_CRC] = s_d.crc_fail;
            if (!s_d.crc_fail)
            begin
               s_d.vout[0] = s_q.mem[0];
               s_d.vout[1] = s_q.mem[1];
               s_d.range = s_q.mem[2][1:0];
               s_d.gcfg = s_q.mem[2][15:8];
               s_d.dev_addr = s_q.mem[3][6:0];
            end
         end
      endcase

      // ==========================================================
      // Faults, setpoints and channel run per channel
      for (int c = 0; c < 2; c++)
      begin
         fin = fault_in[c*NF +: NF];
         s_d.flat[c] = (fclr ? '0 : s_q.flat[c])
                       | (fin & s_q.fmode[c] & ~s_q.fmask[c]);
         act = (s_q.flat[c] | (fin & ~s_q.fmode[c]))
               & ~s_q.fmask[c];
         s_d.chf[c] = |act;
         if (s_q.gcfg[`NCIG_GCFG_IGN_RC] || !resistor_config_present[c])
            mv = s_q.vout[c];
         else
            mv = (c == 0) ? resistor_config_mv0
                          : resistor_config_mv1;
         s_d.dac[c] = ncig_code(mv, s_q.range[c]);
         s_d.run_oe[c] = s_q.crc_fail | s_q.ot_off | s_q.chf[c]
                         | (s_q.ld != ncig_pkg::NCIG_IDLE);
      end
      ev[`NCIG_IRQ_F0] = s_d.chf[0] & ~s_q.chf[0];
      ev[`NCIG_IRQ_F1] = s_d.chf[1] & ~s_q.chf[1];
      s_d.fo0 = |(s_q.chf & s_q.prop0);
      s_d.fo1 = |(s_q.chf & s_q.prop1);

      // ==========================================================
      // Sticky events, set beats clear
      s_d.ist = s_d.ist | ev;
      s_d.irq = |(s_q.ist & ~s_q.imask);
      s_d.alert = s_d.irq | s_q.crc_fail;

      // ==========================================================
      // Serial address acknowledge
      s_d.ack = smb_addr_valid
                && ((smb_addr == `NCIG_ADDR_GLOB0)
                    || (smb_addr == `NCIG_ADDR_GLOB1)
                    || (s_q.crc_fail ? smb_addr == `NCIG_ADDR_RECOV
                                     : smb_addr == s_q.dev_addr));
   end

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '0;
         s_q.ld <= ncig_pkg::NCIG_LOAD;
         s_q.crc <= `NCIG_CRC_INIT;
         s_q.run_oe <= 2'h3;
         s_q.dev_addr <= `NCIG_ADDR_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign flog_ack = s_q.flog_ack;
   assign smb_addr_ack = s_q.ack;
   assign run_oe = s_q.run_oe;
   assign alert_oe = s_q.alert;
   assign fault_output_zero_oe = s_q.fo0;
   assign fault_output_one_oe = s_q.fo1;
   assign irq = s_q.irq;
   assign dac_code0 = s_q.dac[0];
   assign dac_code1 = s_q.dac[1];
endmodule : ncig_top

// [tb/ncig_properties.sv]
// Port checker for the configuration guard, bound into ncig_top
// Assumes pclk domain only, presetn active low
`timescale 1ns/1ps
module ncig_checker #(
   parameter int DEPTH     = 16,
   parameter int CFG_WORDS = 4,
   parameter int NF        = 4
) (
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [7:0]               paddr,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire logic [11:0]              die_temp,
   input wire logic                     die_temp_valid,
   input wire logic                     write_protect,
   input wire logic                     flog_we,
   input wire logic [$clog2(DEPTH)-1:0] flog_addr,
   input wire logic                     flog_ack,
   input wire logic [6:0]               smb_addr,
   input wire logic                     smb_addr_valid,
   input wire logic                     smb_addr_ack,
   input wire logic [1:0]               run_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Bus answer
   a_pready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_pready_one_wait: assert property
      (psel && penable && !pready && !$past(penable) |=> pready)
      else $error("pready not in second access cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_protect_refuse: assert property (pready && pwrite &&
      $past(write_protect) && !(paddr inside {8'h04, 8'h1c, 8'h20})
      |-> pslverr) else $error("write accepted under protect");
   // ==========================================================
   // Serial address, fault log, temperature
   a_global_ack: assert property (smb_addr_valid &&
      (smb_addr == 7'h5a || smb_addr == 7'h5b) |=> smb_addr_ack)
      else $error("global address not answered");
   a_ack_cause: assert property (smb_addr_ack |-> $past(smb_addr_valid))
      else $error("ack without address");
   a_flog_cfg_guard: assert property (flog_ack |->
      $past(flog_we) && $past(flog_addr) > CFG_WORDS)
      else $error("fault log reached config word");
   a_ot_run_off: assert property ((die_temp_valid &&
      $signed(die_temp) > 12'sh0a0) ##1 (!die_temp_valid) [*4]
      |-> run_oe == 2'b11) else $error("controller not off when hot");
endmodule : ncig_checker
bind ncig_top ncig_checker #(.DEPTH(DEPTH), .CFG_WORDS(CFG_WORDS), .NF(NF))
   chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .die_temp(die_temp), .die_temp_valid(die_temp_valid),
   .write_protect(write_protect), .flog_we(flog_we),
   .flog_addr(flog_addr), .flog_ack(flog_ack), .smb_addr(smb_addr),
   .smb_addr_valid(smb_addr_valid), .smb_addr_ack(smb_addr_ack),
   .run_oe(run_oe));

// [tb/ncig_host.sv]
// Serial host model: presents a target address and takes the ack
// Assumes ack is a one-cycle pulse the cycle after the address
`timescale 1ns/1ps
module ncig_host (
   input  wire logic       pclk,
   output logic [6:0]      smb_addr,
   output logic            smb_addr_valid,
   input  wire logic       smb_addr_ack
);
   initial smb_addr = 7'h00;
   initial smb_addr_valid = 1'b0;
   // ==========================================================
   // Address probe, bus shows inverse once released
   task automatic probe(input logic [6:0] a, output logic ack);
      @(posedge pclk);
      smb_addr       <= a;
      smb_addr_valid <= 1'b1;
      @(posedge pclk);
      smb_addr       <= ~a;
      smb_addr_valid <= 1'b0;
      @(posedge pclk);
      ack = smb_addr_ack;
   endtask : probe
endmodule : ncig_host

// [tb/testbench.sv]
// Self-checking bench for the configuration guard over APB
// Assumes blank memory at reset, waits for pready at rising edges
`timescale 1ns/1ps
`include "ncig_map.svh"
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [11:0] die_temp, dac_code0, dac_code1;
   logic        die_temp_valid, write_protect, flog_we, flog_ack, irq;
   logic [3:0]  flog_addr;
   logic [15:0] flog_data;
   logic [6:0]  smb_addr;
   logic        smb_addr_valid, smb_addr_ack, alert_oe;
   logic [1:0]  run_oe, rc_on, fo;
   logic [7:0]  fault_in;
   int          fails, num_checks, cyc;
   ncig_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .die_temp(die_temp), .die_temp_valid(die_temp_valid),
      .write_protect(write_protect), .resistor_config_present(rc_on),
      .resistor_config_mv0(16'h0226), .resistor_config_mv1(16'h0000),
      .fault_in(fault_in), .flog_we(flog_we), .flog_addr(flog_addr),
      .flog_data(flog_data), .flog_ack(flog_ack), .smb_addr(smb_addr),
      .smb_addr_valid(smb_addr_valid), .smb_addr_ack(smb_addr_ack),
      .run_oe(run_oe), .alert_oe(alert_oe), .fault_output_zero_oe(fo[0]),
      .fault_output_one_oe(fo[1]), .irq(irq), .dac_code0(dac_code0),
      .dac_code1(dac_code1));
   ncig_host host (.pclk(pclk), .smb_addr(smb_addr),
      .smb_addr_valid(smb_addr_valid), .smb_addr_ack(smb_addr_ack));
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // ==========================================================
   // Compare, bus and stimulus tasks
   task automatic print_verdict();
      if (fails == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t reg %h exp %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t pin %h exp %h", $time, got, exp);
      end
   endtask : chk_pin
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic e);
      logic [31:0] r;
      logic        s;
      apb(1'b1, a, d, r, s);
      chk_pin({11'h000, s}, {11'h000, e});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        s;
      apb(1'b0, a, 32'h0, r, s);
      chk_reg(r, x);
      chk_pin({11'h000, s}, 12'h000);
   endtask : rd
   task automatic temp(input logic [11:0] t);
      @(posedge pclk);
      die_temp       <= t;
      die_temp_valid <= 1'b1;
      @(posedge pclk);
      die_temp_valid <= 1'b0;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
   endtask : temp
   task automatic flog(input logic [3:0] a, input logic x);
      @(posedge pclk);
      flog_we   <= 1'b1;
      flog_addr <= a;
      @(posedge pclk);
      flog_we   <= 1'b0;
      @(negedge pclk);
      chk_pin({11'h000, flog_ack}, {11'h000, x});
   endtask : flog
   task automatic probe(input logic [6:0] a, input logic x);
      logic k;
      host.probe(a, k);
      chk_pin({11'h000, k}, {11'h000, x});
   endtask : probe
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         fails++;
         print_verdict();
      end
   end
   // ==========================================================
   // Test sequence
   initial
   begin
      {presetn, psel, penable, pwrite, write_protect} = 5'h00;
      {paddr, pwdata, die_temp, die_temp_valid} = 53'h0;
      {flog_we, flog_addr, flog_data} = {1'b0, 4'h0, 16'h0bad};
      {rc_on, fault_in} = 10'h000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      @(negedge pclk);
      chk_pin({10'h000, run_oe}, 12'h000);
      rd(`NCIG_A_SMFR, 32'h0);
      wr(8'h44, 32'h1, 1'b1);
      wr(`NCIG_A_DAC, 32'h1, 1'b1);
      wr(`NCIG_A_PAGE, 32'h0, 1'b0);
      wr(`NCIG_A_VOUT, 32'h0000044c, 1'b0);
      repeat (4) @(posedge pclk);
      chk_pin(dac_code0, 12'h320);
      wr(`NCIG_A_RANGE, 32'h1, 1'b0);
      repeat (4) @(posedge pclk);
      chk_pin(dac_code0, 12'h640);
      rc_on <= 2'h1;
      repeat (4) @(posedge pclk);
      chk_pin(dac_code0, 12'h320);
      wr(`NCIG_A_GCFG, 32'h40, 1'b0);
      repeat (4) @(posedge pclk);
      chk_pin(dac_code0, 12'h640);
      wr(`NCIG_A_PAGE, 32'h1, 1'b0);
      wr(`NCIG_A_VOUT, 32'h00002af8, 1'b0);
      repeat (4) @(posedge pclk);
      chk_pin(dac_code1, 12'hfff);
      chk_pin(dac_code0, 12'h640);
      rd(`NCIG_A_DAC, 32'h00000fff);
      write_protect <= 1'b1;
      wr(`NCIG_A_VOUT, 32'h1, 1'b1);
      wr(`NCIG_A_PAGE, 32'h0, 1'b0);
      write_protect <= 1'b0;
      // Host keeps NVM writes below 85 C except in this stress
      temp(12'h083);
      rd(`NCIG_A_SMFR, 32'h2);
      wr(`NCIG_A_NDATA, 32'h1, 1'b1);
      flog(4'h5, 1'b0);
      rd(`NCIG_A_IST, 32'h4);
      chk_pin({10'h000, irq, alert_oe}, 12'h003);
      wr(`NCIG_A_IMASK, 32'h4, 1'b0);
      repeat (2) @(posedge pclk);
      chk_pin({11'h000, irq}, 12'h000);
      wr(`NCIG_A_IMASK, 32'h0, 1'b0);
      wr(`NCIG_A_IST, 32'h4, 1'b0);
      rd(`NCIG_A_IST, 32'h0);
      chk_pin({11'h000, irq}, 12'h000);
      temp(12'h080);
      rd(`NCIG_A_SMFR, 32'h2);
      temp(12'h07c);
      rd(`NCIG_A_SMFR, 32'h0);
      flog(4'h5, 1'b1);
      flog(4'h4, 1'b0);
      temp(12'h0a1);
      chk_pin({10'h000, run_oe}, 12'h003);
      temp(12'h097);
      chk_pin({10'h000, run_oe}, 12'h003);
      temp(12'h095);
      chk_pin({10'h000, run_oe}, 12'h000);
      temp(12'h019);
      wr(`NCIG_A_IST, 32'h2, 1'b0);
      wr(`NCIG_A_PROP, 32'h2, 1'b0);
      wr(`NCIG_A_PAGE, 32'h1, 1'b0);
      wr(`NCIG_A_FLATCH, 32'h1, 1'b0);
      fault_in <= 8'h10;
      repeat (4) @(posedge pclk);
      chk_pin({8'h00, fo, run_oe}, 12'h006);
      fault_in <= 8'h00;
      repeat (4) @(posedge pclk);
      chk_pin({8'h00, fo, run_oe}, 12'h006);
      wr(`NCIG_A_CTRL, 32'h2, 1'b0);
      repeat (4) @(posedge pclk);
      chk_pin({8'h00, fo, run_oe}, 12'h000);
      probe(7'h00, 1'b1);
      probe(7'h7c, 1'b0);
      wr(`NCIG_A_NADDR, 32'h0, 1'b0);
      wr(`NCIG_A_NDATA, 32'h00001234, 1'b0);
      wr(`NCIG_A_CTRL, 32'h1, 1'b0);
      repeat (10) @(posedge pclk);
      @(negedge pclk);
      chk_pin({9'h000, alert_oe, run_oe}, 12'h007);
      rd(`NCIG_A_SMFR, 32'h1);
      rd(`NCIG_A_SWORD, 32'h00001001);
      probe(7'h7c, 1'b1);
      probe(7'h5a, 1'b1);
      probe(7'h5b, 1'b1);
      probe(7'h00, 1'b0);
      print_verdict();
   end
endmodule : testbench
